// >>> core/wgn_netmgmt.v
// Purpose: gateway network management: serial register port, command
//   decode, node join/remove tracking and per-page node identification
// Assumes: serial port pins synchronous to clk_sys_i; mode 3 framing,
//   16-bit frames, bit 15 write flag, bits 14:8 address, 7:0 data
// Notes:
// Notes on behaviour
// - self-initialize, then join only under host control
// - join may take ten seconds; window held
// - node select holds 0..6 in bits 3:0; code stores any 4-bit value, node commands above 6 dropped except alarm transfer
// - command bit 15 removes selected node
// - bit 13 requests node configuration and payload
// - bit 11 reads alarms, bit 10 transfers
// - bit 12 updates selected node alarm registers
// - bit 1 updates node registers except alarms
// - bits 7,6,5: reset, flash save, test
// - bit 4 diag clear, bit 3 factory
// - network identifier resets to 0x1234
// - unused page identification reads zero
// - linked page shows code and node number
// - received strength is signed dBm count
// - channel code bits 13:8, max 50
// - power code bits 4:0, max 15
`timescale 1ns/1ps
`include "wgn_defines.vh"

module wgn_netmgmt #(
	parameter JOIN_CYCLES = `WGN_JOIN_CYCLES, // join window length
	parameter INIT_CYCLES = `WGN_INIT_CYCLES, // self-init length
	parameter [7:0] LINK_CODE = 8'h5C, // arbitrary connection code
	parameter PAGES = 6 // pages that can manage a node
) (
	input wire clk_sys_i,
	input wire rst_n_i,
	input wire spi_cs_n_i,
	input wire spi_sclk_i,
	input wire spi_mosi_i,
	output reg spi_miso_o,
	output reg spi_miso_oe_o,
	input wire join_done_i,
	input wire [2:0] join_node_i,
	input wire [15:0] rx_strength_i,
	output reg [5:0] radio_channel_o,
	output reg [4:0] radio_power_o,
	output reg ready_o,
	output reg join_busy_o,
	output reg [2:0] cmd_node_o,
	output reg cmd_add_o,
	output reg cmd_remove_o,
	output reg cmd_update_o,
	output reg cmd_req_cfg_o,
	output reg cmd_alm_read_o,
	output reg cmd_alm_xfer_o,
	output reg cmd_alm_upd_o,
	output reg cmd_soft_rst_o,
	output reg cmd_flash_save_o,
	output reg cmd_flash_test_o,
	output reg cmd_diag_clr_o,
	output reg cmd_factory_o
);

	////////////////////////////////////////////////////////////////////
	// state codes
	localparam [1:0] ST_INIT = 2'h0; // self-initialising
	localparam [1:0] ST_IDLE = 2'h1; // ready, no join open
	localparam [1:0] ST_ARMED = 2'h2; // add armed, waiting for node
	localparam [1:0] ST_JOIN = 2'h3; // join window open

	////////////////////////////////////////////////////////////////////
	// serial port state
	reg sclk_q; // previous clock level for edge detect
	reg cs_q; // previous select level
	reg [3:0] bit_cnt; // bits taken in this frame
	reg [15:0] in_sr; // incoming frame
	reg [15:0] out_sr; // outgoing frame
	reg [15:0] rd_word; // word prepared for next frame
	wire sclk_rise = spi_sclk_i & ~sclk_q & ~spi_cs_n_i;
	wire sclk_fall = ~spi_sclk_i & sclk_q & ~spi_cs_n_i;
	wire frame_go = cs_q & ~spi_cs_n_i; // select falling
	wire [15:0] frame = {in_sr[14:0], spi_mosi_i};
	wire frame_done = sclk_rise & (bit_cnt == 4'hF);
	wire wr_en = frame_done & frame[15];
	wire [6:0] f_addr = frame[14:8];
	wire [7:0] f_data = frame[7:0];
	wire [6:0] w_addr = {f_addr[6:1], 1'b0}; // word address of the frame

	// registers
	reg [2:0] page; // page select
	reg [15:0] net_id; // net_identifier
	reg [5:0] chan; // gateway_radio_setting channel
	reg [4:0] pwr; // gateway_radio_setting power
	reg [3:0] node_sel; // target_node_select
	reg [15:0] rx_str; // gateway_rx_strength
	reg [PAGES-1:0] pg_used; // page manages a link
	reg [2:0] pg_node [0:PAGES-1]; // node held by each page

	// control
	reg [1:0] state;
	reg [31:0] tmr; // init and join window count
	reg [2:0] join_node; // node being joined
	reg [15:0] next_rd; // read mux result
	reg [15:0] cmd; // command bits of this write
	integer i;
	reg found; // free page already taken
	reg [PAGES-1:0] free_one; // lowest free page, one-hot
	integer j; // index of the free page search

	wire node_ok = (node_sel <= `WGN_NODE_MAX);
	wire pg0 = (page == 3'h0);
	wire cmd_lo = wr_en & pg0 & (f_addr == `WGN_ADDR_CMD);
	wire cmd_hi = wr_en & pg0 & (f_addr == (`WGN_ADDR_CMD | 7'h01));
	wire sel_wr = wr_en & pg0 & (f_addr == `WGN_ADDR_NODE_SEL);
	wire soft_rst = cmd[`WGN_CMD_SOFT_RST];
	wire factory = cmd[`WGN_CMD_FACTORY];
	// radio reset word, taken apart by field so no bits are dropped
	wire [15:0] radio_rst = `WGN_RADIO_RST;

	////////////////////////////////////////////////////////////////////
	// command word built from a byte write to either half
	always @* begin
		cmd = 16'h0000;
		if (cmd_lo) begin
			cmd[7:0] = f_data;
		end
		if (cmd_hi) begin
			cmd[15:8] = f_data;
		end
	end

	////////////////////////////////////////////////////////////////////
	// read mux; odd addresses read the same word
	always @* begin
		next_rd = 16'h0000;
		if (w_addr == `WGN_ADDR_PAGE) begin
			next_rd = {13'h0000, page};
		end else if (pg0) begin
			case (w_addr)
				`WGN_ADDR_NET_ID: next_rd = net_id;
				`WGN_ADDR_RADIO: next_rd = {2'h0, chan, 3'h0, pwr};
				`WGN_ADDR_RX_STR: next_rd = rx_str;
				`WGN_ADDR_NODE_SEL: next_rd = {12'h000, node_sel};
				default: next_rd = 16'h0000; // command is write only
			endcase
		end else if (page <= PAGES &&
			w_addr == `WGN_ADDR_LINK_IDENT) begin
			if (pg_used[page - 3'h1]) begin
				next_rd = {LINK_CODE, 5'h00,
					pg_node[page - 3'h1]};
			end else begin
				next_rd = 16'h0000;
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// lowest free page; one-hot so a finished join claims one page only
	always @* begin
		free_one = {PAGES{1'b0}};
		found = 1'b0;
		for (j = 0; j < PAGES; j = j + 1) begin
			if (!found && !pg_used[j]) begin
				free_one[j] = 1'b1;
				found = 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// serial shift logic, mode 3: sample on rise, shift on fall
	always @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			sclk_q <= 1'b1;
			cs_q <= 1'b1;
			bit_cnt <= 4'h0;
			in_sr <= 16'h0000;
			out_sr <= 16'h0000;
			rd_word <= 16'h0000;
			spi_miso_o <= 1'b0;
			spi_miso_oe_o <= 1'b0;
		end else begin
			sclk_q <= spi_sclk_i;
			cs_q <= spi_cs_n_i;
			spi_miso_oe_o <= ~spi_cs_n_i;
			if (frame_go) begin
				// frame start: present prepared word
				bit_cnt <= 4'h0;
				out_sr <= rd_word;
				spi_miso_o <= rd_word[15];
			end else if (sclk_fall && bit_cnt != 4'h0) begin
				// next bit out
				spi_miso_o <= out_sr[14];
				out_sr <= {out_sr[14:0], 1'b0};
			end
			if (sclk_rise) begin
				in_sr <= frame;
				bit_cnt <= bit_cnt + 4'h1;
			end
			if (frame_done && !frame[15]) begin
				// read request answered in the next frame
				rd_word <= next_rd;
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// registers, command decode and link tracking
	always @(posedge clk_sys_i) begin
		if (!rst_n_i || soft_rst) begin
			page <= 3'h0;
			net_id <= `WGN_NET_ID_RST;
			chan <= radio_rst[13:8];
			pwr <= radio_rst[4:0];
			node_sel <= `WGN_NODE_SEL_RST;
			pg_used <= {PAGES{1'b0}};
			for (i = 0; i < PAGES; i = i + 1) begin
				pg_node[i] <= 3'h0;
			end
			state <= ST_INIT;
			tmr <= 32'h00000000;
			join_node <= 3'h0;
			ready_o <= 1'b0;
			join_busy_o <= 1'b0;
			cmd_node_o <= 3'h0;
			cmd_add_o <= 1'b0;
			cmd_remove_o <= 1'b0;
			cmd_update_o <= 1'b0;
			cmd_req_cfg_o <= 1'b0;
			cmd_alm_read_o <= 1'b0;
			cmd_alm_xfer_o <= 1'b0;
			cmd_alm_upd_o <= 1'b0;
			cmd_flash_save_o <= 1'b0;
			cmd_flash_test_o <= 1'b0;
			cmd_diag_clr_o <= 1'b0;
			cmd_factory_o <= 1'b0;
			// reset pulse leaves the block on a soft reset only
			cmd_soft_rst_o <= rst_n_i;
			radio_channel_o <= radio_rst[13:8];
			radio_power_o <= radio_rst[4:0];
		end else begin
			rx_str <= rx_strength_i;
			radio_channel_o <= chan;
			radio_power_o <= pwr;
			cmd_soft_rst_o <= 1'b0;
			cmd_node_o <= node_sel[2:0];
			// node-directed pulses, dropped for a bad node; alarm transfer is passed without the node check
			cmd_update_o <= cmd[`WGN_CMD_UPDATE] & node_ok;
			cmd_req_cfg_o <= cmd[`WGN_CMD_REQ_CFG] & node_ok;
			cmd_alm_read_o <= cmd[`WGN_CMD_ALM_READ] & node_ok;
			cmd_alm_xfer_o <= cmd[`WGN_CMD_ALM_XFER];
			cmd_alm_upd_o <= cmd[`WGN_CMD_ALM_UPD] & node_ok;
			cmd_flash_save_o <= cmd[`WGN_CMD_FLASH_SAVE];
			cmd_flash_test_o <= cmd[`WGN_CMD_FLASH_TEST];
			cmd_diag_clr_o <= cmd[`WGN_CMD_DIAG_CLR];
			cmd_factory_o <= factory;
			cmd_add_o <= 1'b0;
			cmd_remove_o <= 1'b0;
			// plain register writes
			if (wr_en && f_addr == `WGN_ADDR_PAGE) begin
				page <= f_data[2:0];
			end
			if (wr_en && pg0) begin
				case (f_addr)
					`WGN_ADDR_NET_ID: net_id[7:0] <= f_data;
					`WGN_ADDR_NET_ID | 7'h01: net_id[15:8] <= f_data;
					`WGN_ADDR_RADIO: pwr <= (f_data[4:0] > `WGN_PWR_MAX) ?
						`WGN_PWR_MAX : f_data[4:0];
					`WGN_ADDR_RADIO | 7'h01: chan <=
						(f_data[5:0] > `WGN_CHAN_MAX) ?
						`WGN_CHAN_MAX : f_data[5:0];
					`WGN_ADDR_NODE_SEL: node_sel <= f_data[3:0];
					default: ;
				endcase
			end
			// factory restore returns settings to defaults
			if (factory) begin
				net_id <= `WGN_NET_ID_RST;
				chan <= radio_rst[13:8];
				pwr <= radio_rst[4:0];
			end
			// remove: free the page holding the selected node
			if ((cmd[`WGN_CMD_REMOVE] || cmd[`WGN_CMD_REMOVE2]) &&
				node_ok) begin
				cmd_remove_o <= 1'b1;
				for (i = 0; i < PAGES; i = i + 1) begin
					if (pg_node[i] == node_sel[2:0]) begin
						pg_used[i] <= 1'b0;
					end
				end
			end
			// join sequence
			case (state)
				ST_INIT: begin
					// self-init, no join requests accepted
					if (tmr >= INIT_CYCLES - 1) begin
						state <= ST_IDLE;
						tmr <= 32'h00000000;
						ready_o <= 1'b1;
					end else begin
						tmr <= tmr + 32'h00000001;
					end
				end
				ST_IDLE: begin
					if (cmd[`WGN_CMD_ADD]) begin
						state <= ST_ARMED;
					end
				end
				ST_ARMED: begin
					// node number 0..6 written after arming starts the join; a larger one returns to idle
					if (sel_wr) begin
						if (f_data[3:0] <= `WGN_NODE_MAX) begin
							state <= ST_JOIN;
							join_node <= f_data[2:0];
							cmd_node_o <= f_data[2:0];
							cmd_add_o <= 1'b1;
							join_busy_o <= 1'b1;
							tmr <= 32'h00000000;
						end else begin
							state <= ST_IDLE;
						end
					end
				end
				ST_JOIN: begin
					// window open until the joining node reports done or the join time runs out
					if (join_done_i && join_node_i == join_node) begin
						// claim the lowest free page; a full table drops it
						for (i = 0; i < PAGES; i = i + 1) begin
							if (free_one[i]) begin
								pg_used[i] <= 1'b1;
								pg_node[i] <= join_node;
							end
						end
						state <= ST_IDLE;
						join_busy_o <= 1'b0;
					end else if (tmr >= JOIN_CYCLES - 1) begin
						state <= ST_IDLE;
						join_busy_o <= 1'b0;
					end else begin
						tmr <= tmr + 32'h00000001;
					end
				end
				default: state <= ST_IDLE;
			endcase
		end
	end

endmodule // wgn_netmgmt

// >>> core/wgn_defines.vh
// Purpose: constants for the gateway network management block
// Assumes: 7-bit byte addresses, 16-bit registers on even addresses
// Notes: included by core/wgn_netmgmt.v only
`ifndef WGN_DEFINES_VH
`define WGN_DEFINES_VH

// byte addresses, page 0 except page select (every page) and link ident (pages 1 to 6)
`define WGN_ADDR_PAGE 7'h00
`define WGN_ADDR_NET_ID 7'h02
`define WGN_ADDR_LINK_IDENT 7'h02
`define WGN_ADDR_RADIO 7'h08
`define WGN_ADDR_RX_STR 7'h0A
`define WGN_ADDR_CMD 7'h12
`define WGN_ADDR_NODE_SEL 7'h14

// reset values
`define WGN_NET_ID_RST 16'h1234
`define WGN_RADIO_RST 16'h0008
`define WGN_NODE_SEL_RST 4'h0

// gateway_command bit positions
`define WGN_CMD_ADD 0
`define WGN_CMD_UPDATE 1
`define WGN_CMD_FACTORY 3
`define WGN_CMD_DIAG_CLR 4
`define WGN_CMD_FLASH_TEST 5
`define WGN_CMD_FLASH_SAVE 6
`define WGN_CMD_SOFT_RST 7
`define WGN_CMD_REMOVE 8
`define WGN_CMD_ALM_XFER 10
`define WGN_CMD_ALM_READ 11
`define WGN_CMD_ALM_UPD 12
`define WGN_CMD_REQ_CFG 13
`define WGN_CMD_REMOVE2 15

// field limits
`define WGN_NODE_MAX 4'h6
`define WGN_CHAN_MAX 6'h32
`define WGN_PWR_MAX 5'h0F

// timing
`define WGN_CLK_KHZ 10000
`define WGN_JOIN_TIME_MS 10000
`define WGN_JOIN_CYCLES (`WGN_JOIN_TIME_MS * `WGN_CLK_KHZ)
`define WGN_INIT_CYCLES 16

`endif

// >>> bench/wgn_chk_asserts.sv
// Purpose: port assertions for the network management block
// Assumes: one clock, synchronous active-low reset
// Notes: attached to every instance by the bind at the foot
`timescale 1ns/1ps
module wgn_chk #(
	parameter JOIN_CYCLES = 200
) (
	input wire clk_sys_i,
	input wire rst_n_i,
	input wire spi_cs_n_i,
	input wire spi_miso_oe_o,
	input wire [5:0] radio_channel_o,
	input wire [4:0] radio_power_o,
	input wire ready_o,
	input wire join_busy_o,
	input wire [2:0] cmd_node_o,
	input wire cmd_add_o,
	input wire cmd_remove_o,
	input wire cmd_update_o,
	input wire cmd_req_cfg_o,
	input wire cmd_alm_read_o,
	input wire cmd_alm_upd_o,
	input wire cmd_soft_rst_o,
	input wire cmd_factory_o
);
default clocking @(posedge clk_sys_i); endclocking
default disable iff (!rst_n_i);
reg [31:0] open_cnt; // cycles the join window has stayed open
// count the open window so a stuck window is caught
always @(posedge clk_sys_i) begin
	if (!rst_n_i || !join_busy_o)
		open_cnt <= 32'h00000000;
	else
		open_cnt <= open_cnt + 32'h00000001;
end
property p_add_ready;
	cmd_add_o |-> ready_o && join_busy_o && cmd_node_o <= 3'h6;
endproperty
a_add_ready: assert property (p_add_ready) else $error("bad add");
property p_busy_open;
	$rose(join_busy_o) |-> cmd_add_o;
endproperty
a_busy_open: assert property (p_busy_open) else $error("stray join");
property p_join_bound;
	open_cnt <= JOIN_CYCLES + 2;
endproperty
a_join_bound: assert property (p_join_bound) else $error("join long");
property p_node_range;
	(cmd_remove_o || cmd_update_o || cmd_req_cfg_o || cmd_alm_read_o
		|| cmd_alm_upd_o) |-> cmd_node_o <= 3'h6;
endproperty
a_node_range: assert property (p_node_range) else $error("node >6");
property p_power_max;
	radio_power_o <= 5'h0F;
endproperty
a_power_max: assert property (p_power_max) else $error("power");
property p_chan_max;
	radio_channel_o <= 6'h32;
endproperty
a_chan_max: assert property (p_chan_max) else $error("channel");
property p_factory;
	cmd_factory_o |-> ##[0:2] radio_power_o == 5'h08 &&
		radio_channel_o == 6'h00;
endproperty
a_factory: assert property (p_factory) else $error("factory");
property p_soft;
	cmd_soft_rst_o |-> ##[0:2] !join_busy_o;
endproperty
a_soft: assert property (p_soft) else $error("soft reset");
property p_pulse;
	cmd_update_o |=> !cmd_update_o;
endproperty
a_pulse: assert property (p_pulse) else $error("update pulse");
property p_miso_oe;
	spi_miso_oe_o == !$past(spi_cs_n_i);
endproperty
a_miso_oe: assert property (p_miso_oe) else $error("miso enable");
endmodule // wgn_chk
bind wgn_netmgmt wgn_chk #(.JOIN_CYCLES(JOIN_CYCLES)) u_chk (
	.clk_sys_i, .rst_n_i, .spi_cs_n_i, .spi_miso_oe_o,
	.radio_channel_o, .radio_power_o, .ready_o,
	.join_busy_o, .cmd_node_o, .cmd_add_o, .cmd_remove_o, .cmd_update_o,
	.cmd_req_cfg_o, .cmd_alm_read_o, .cmd_alm_upd_o, .cmd_soft_rst_o,
	.cmd_factory_o);

// >>> bench/wgn_host.sv
// Purpose: host controller model on the serial register port
// Assumes: mode 3, four clocks per serial half period
// Notes: mosi idles at the inverse of its last bit
`timescale 1ns/1ps
module wgn_host (
	input wire clk_i,
	input wire miso_i,
	output reg cs_n_o,
	output reg sclk_o,
	output reg mosi_o
);
initial begin
	cs_n_o = 1'b1;
	sclk_o = 1'b1;
	mosi_o = 1'b0;
end
// one 16-bit frame, msb first; miso taken at each rise
task xfer(input [15:0] tx, output [15:0] rx);
	integer i;
	begin
		@(posedge clk_i) cs_n_o <= 1'b0;
		for (i = 15; i >= 0; i = i - 1) begin
			repeat (4) @(posedge clk_i);
			sclk_o <= 1'b0;
			mosi_o <= tx[i];
			repeat (4) @(posedge clk_i);
			sclk_o <= 1'b1;
			rx[i] = miso_i;
		end
		repeat (4) @(posedge clk_i);
		cs_n_o <= 1'b1;
		mosi_o <= ~tx[0];
		repeat (3) @(posedge clk_i);
	end
endtask
// arm add, wait 500 us, then name the node
task add_node(input [7:0] n);
	reg [15:0] t;
	begin
		xfer(16'h9201, t);
		repeat (5000) @(posedge clk_i);
		xfer({8'h94, n}, t);
	end
endtask
// name the node, then issue remove
task remove_node(input [7:0] n);
	reg [15:0] t;
	begin
		xfer({8'h94, n}, t);
		xfer(16'h9301, t);
	end
endtask
endmodule // wgn_host

// >>> bench/tb_wireless_gateway_network_mgmt.sv
// Purpose: self-checking bench for the network management block
// Assumes: short join window of 200 cycles
// Notes: host model drives the serial port
`timescale 1ns/1ps
module tb_wireless_gateway_network_mgmt;
reg clk_sys_i = 1'b0;
reg rst_n_i = 1'b0;
reg join_done = 1'b0;
reg [2:0] join_node = 3'h0;
reg [15:0] rx_str = 16'h0000;
wire cs_n, sclk, mosi, miso, ready_o, busy;
wire [5:0] chan;
wire [4:0] pwr;
wire [2:0] node;
wire [15:0] pul; // command pulses by command bit
integer err_total = 0, compares = 0, cyc = 0, npul = 0, b;
reg [15:0] last_pul = 16'h0000, d;
initial forever #50 clk_sys_i = ~clk_sys_i;
wgn_host host (.clk_i(clk_sys_i), .miso_i(miso), .cs_n_o(cs_n),
	.sclk_o(sclk), .mosi_o(mosi));
wgn_netmgmt #(.JOIN_CYCLES(200)) dut (.clk_sys_i(clk_sys_i),
	.rst_n_i(rst_n_i), .spi_cs_n_i(cs_n), .spi_sclk_i(sclk),
	.spi_mosi_i(mosi), .spi_miso_o(miso), .spi_miso_oe_o(),
	.join_done_i(join_done), .join_node_i(join_node),
	.rx_strength_i(rx_str), .radio_channel_o(chan), .radio_power_o(pwr),
	.ready_o(ready_o), .join_busy_o(busy), .cmd_node_o(node),
	.cmd_add_o(pul[0]), .cmd_remove_o(pul[8]), .cmd_update_o(pul[1]),
	.cmd_req_cfg_o(pul[13]), .cmd_alm_read_o(pul[11]),
	.cmd_alm_xfer_o(pul[10]), .cmd_alm_upd_o(pul[12]),
	.cmd_soft_rst_o(pul[7]), .cmd_flash_save_o(pul[6]),
	.cmd_flash_test_o(pul[5]), .cmd_diag_clr_o(pul[4]),
	.cmd_factory_o(pul[3]));
assign {pul[15], pul[14], pul[9], pul[2]} = {pul[8], 3'h0};
// record pulses and cut a hang short
always @(posedge clk_sys_i) begin
	cyc <= cyc + 1;
	if (pul != 16'h0000) begin
		npul <= npul + 1;
		last_pul <= pul;
	end
	if (cyc == 40000) begin
		err_total = err_total + 1;
		test_done;
	end
end
task chk(input [79:0] nm, input [15:0] got, input [15:0] exp);
	begin
		compares = compares + 1;
		if (got !== exp) begin
			err_total = err_total + 1;
			$display("[FAIL] %0s expected %h seen %h", nm, exp, got);
		end
	end
endtask
task wr(input [6:0] a, input [7:0] v);
	reg [15:0] t;
	host.xfer({1'b1, a, v}, t);
endtask
task rd(input [6:0] a, output [15:0] v);
	reg [15:0] t;
	begin
		host.xfer({1'b0, a, 8'h00}, t);
		host.xfer(16'h0000, v);
	end
endtask
// reset values, write-only command and net_identifier storage
task t_regs;
	begin
		chk("ready", ready_o, 16'h0001);
		rd(7'h02, d); chk("netid", d, 16'h1234);
		rd(7'h08, d); chk("radio", d, 16'h0008);
		rd(7'h14, d); chk("nodesel", d, 16'h0000);
		rd(7'h12, d); chk("cmdread", d, 16'h0000);
		wr(7'h02, 8'h56); wr(7'h03, 8'hAB);
		rd(7'h02, d); chk("netid", d, 16'hAB56);
	end
endtask
// saturation, field positions and signed strength
task t_radio;
	begin
		wr(7'h08, 8'hFF); wr(7'h09, 8'hFF);
		chk("power", pwr, 16'h000F);
		chk("chan", chan, 16'h0032);
		wr(7'h08, 8'h0E); wr(7'h09, 8'h31);
		rd(7'h08, d); chk("radio", d, 16'h310E);
		rx_str <= 16'hFFA0;
		rd(7'h0A, d); chk("rxstr", d, 16'hFFA0);
	end
endtask
// join, page identification, removal and join timeout
task t_join;
	begin
		host.add_node(8'h03);
		chk("busy", busy, 16'h0001);
		join_node <= 3'h3; join_done <= 1'b1;
		@(posedge clk_sys_i) join_done <= 1'b0;
		repeat (2) @(posedge clk_sys_i);
		chk("busy", busy, 16'h0000);
		wr(7'h00, 8'h01); rd(7'h02, d); chk("page1", d, 16'h5C03);
		wr(7'h00, 8'h02); rd(7'h02, d); chk("page2", d, 16'h0000);
		wr(7'h00, 8'h00); host.remove_node(8'h03);
		wr(7'h00, 8'h01); rd(7'h02, d); chk("page1", d, 16'h0000);
		wr(7'h00, 8'h00); host.add_node(8'h04);
		repeat (220) @(posedge clk_sys_i);
		chk("busy", busy, 16'h0000);
		wr(7'h00, 8'h01); rd(7'h02, d); chk("page1", d, 16'h0000);
		wr(7'h00, 8'h00);
	end
endtask
// command bits 1 to 15, then a node-directed command with node 7
task t_cmds;
	integer n;
	reg [15:0] e;
	begin
		wr(7'h14, 8'h02);
		rd(7'h14, d); chk("nodesel", d, 16'h0002);
		for (b = 1; b < 16; b = b + 1) begin
			n = npul;
			wr(b < 8 ? 7'h12 : 7'h13, 8'h01 << b[2:0]);
			if (b == 1)
				chk("node", node, 16'h0002);
			if (b == 7)
				chk("ready", ready_o, 16'h0000);
			if (b == 8)
				chk("ready", ready_o, 16'h0001);
			e = (b == 8 || b == 15) ? 16'h8100 : 16'h0001 << b;
			if (b == 2 || b == 9 || b == 14)
				chk("noop", npul - n, 16'h0000);
			else begin
				chk("npulse", npul - n, 16'h0001);
				chk("pulse", last_pul, e);
			end
		end
		chk("power", pwr, 16'h0008);
		repeat (20) @(posedge clk_sys_i);
		wr(7'h14, 8'h07); n = npul; wr(7'h13, 8'h20);
		chk("gated", npul - n, 16'h0000);
	end
endtask
task test_done;
	begin
		$display("compares %0d err_total %0d", compares, err_total);
		if (err_total == 0 && compares > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	end
endtask
initial begin
	repeat (12) @(posedge clk_sys_i);
	rst_n_i <= 1'b1;
	repeat (20) @(posedge clk_sys_i);
	t_regs; t_radio; t_join; t_cmds;
	test_done;
end
endmodule // tb_wireless_gateway_network_mgmt
